// ===== rtl/brake_chopper_defs.svh
// Constants for the braking chopper: widths, field positions and timing counts.
`ifndef BRAKE_CHOPPER_DEFS_SVH
`define BRAKE_CHOPPER_DEFS_SVH

// Bus voltage and threshold width, in volts.
`define VOLT_W            12
// Duty width and the number of modulation steps per period.
`define DUTY_W            7
`define DUTY_STEPS        7'h64
// Width of the proportional numerator (volts times steps plus rounding).
`define NUM_W             19
// Thermal level that counts as fully hot, in percent.
`define THERMAL_FULL_PCT  7'h64
// Width of the trip detection action setting and its resistor model bit.
`define TRIP_ACTION_W     8
`define TRIP_ACTION_RES   2
// Number of priority trip levels that inhibit braking.
`define PRIO_LEVELS       3
// Clock rate and the least on-time, with the derived cycle count.
`define CLK_FREQ_MHZ      200
`define MIN_ON_TIME_US    1000
`define MIN_ON_CYCLES     (`MIN_ON_TIME_US * `CLK_FREQ_MHZ)
// One modulation step lasts as long as the least on-time.
`define STEP_CYCLES       (`MIN_ON_TIME_US * `CLK_FREQ_MHZ)
// Width of the cycle counters.
`define CNT_W             18

`endif

// ===== rtl/brake_chopper_pkg.sv
// Types shared by the braking chopper files.
`include "brake_chopper_defs.svh"

package brake_chopper_pkg;

   typedef enum logic [1:0] {
      MODE_OFF,
      MODE_LOW_VOLT,
      MODE_COMPARE,
      MODE_PROPORTIONAL
   } brake_mode_t;

   typedef enum logic [1:0] {
      GATE_OFF,
      GATE_MIN_ON,
      GATE_ON
   } gate_state_t;

   typedef struct packed {
      logic [`VOLT_W-1:0] lower_thr;
      logic [`VOLT_W-1:0] upper_thr;
      logic [`VOLT_W-1:0] low_volt_thr;
      logic               low_volt_select;
      logic [`VOLT_W-1:0] max_dc_voltage_setting;
   } brake_cfg_t;

   typedef struct packed {
      logic brake_overcurrent_trip;
      logic internal_supply_trip;
      logic resistor_thermal_trip;
      logic inverter_overtemp_trip;
   } brake_trips_t;

   typedef struct packed {
      logic                      under_voltage;
      logic [`PRIO_LEVELS-1:0]   priority_trip;
      brake_trips_t              trips;
      logic [`DUTY_W-1:0]        thermal_level_pct;
      logic                      resistor_hot_alarm;
      logic [`TRIP_ACTION_W-1:0] trip_action;
      logic                      resistor_model_hot;
   } brake_protect_t;

endpackage

// ===== rtl/duty_divider.sv
// Sequential restoring divider that turns a voltage span into a clamped duty.
`timescale 1ns/1ps
`default_nettype none
`include "brake_chopper_defs.svh"

module duty_divider (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Request
   input  wire logic              start_i,
   input  wire logic [`NUM_W-1:0]  numer_i,
   input  wire logic [`VOLT_W-1:0] denom_i,
   // Result
   output logic                   done_o,
   output logic [`DUTY_W-1:0]      duty_o
);

   logic [`NUM_W-1:0]  quo_ff;
   logic [`VOLT_W:0]   rem_ff;
   logic [`VOLT_W-1:0] den_ff;
   logic [4:0]         cnt_ff;
   logic               busy_ff;
   logic [`VOLT_W:0]   trial;

   assign trial = {rem_ff[`VOLT_W-1:0], quo_ff[`NUM_W-1]};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         quo_ff  <= '0;
         rem_ff  <= '0;
         den_ff  <= '0;
         cnt_ff  <= '0;
         busy_ff <= 1'b0;
      end else if (start_i) begin
         quo_ff  <= numer_i;
         rem_ff  <= '0;
         den_ff  <= denom_i;
         cnt_ff  <= 5'(`NUM_W);
         busy_ff <= 1'b1;
      end else if (busy_ff) begin
         if (trial >= {1'b0, den_ff}) begin
            rem_ff <= trial - {1'b0, den_ff};
            quo_ff <= {quo_ff[`NUM_W-2:0], 1'b1};
         end else begin
            rem_ff <= trial;
            quo_ff <= {quo_ff[`NUM_W-2:0], 1'b0};
         end
         cnt_ff <= cnt_ff - 5'h01;
         if (cnt_ff == 5'h01) begin
            busy_ff <= 1'b0;
         end
      end
   end

   // Result is clamped so rounding can never exceed a full period.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_o <= 1'b0;
         duty_o <= '0;
      end else begin
         done_o <= busy_ff && (cnt_ff == 5'h01);
         if (busy_ff && (cnt_ff == 5'h01)) begin
            if ({quo_ff[`NUM_W-2:0], trial >= {1'b0, den_ff}} > `NUM_W'(`DUTY_STEPS)) begin
               duty_o <= `DUTY_STEPS;
            end else begin
               duty_o <= `DUTY_W'({quo_ff[`NUM_W-2:0], trial >= {1'b0, den_ff}});
            end
         end
      end
   end

endmodule
`default_nettype wire

// ===== rtl/brake_chopper_control.sv
// Braking transistor control from the measured DC bus voltage.
// What this block does
// [RULE_01] Lower threshold starts switching, upper means continuous.
// [RULE_02] Every turn-on lasts at least 1 ms unless an inhibit cuts it short.
// [RULE_03] Duty 0 below, proportional between, full above.
// [RULE_04] Just above lower threshold, one step in hundred.
// [RULE_05] Lower not below upper: simple comparator.
// [RULE_06] Zero upper threshold, or zero low-voltage threshold when low-voltage select is set, disables.
// [RULE_07] Under-voltage state keeps the transistor off.
// [RULE_08] Priority one to three trips disable braking.
// [RULE_09] Brake, supply, thermal trips disable, even masked.
// [RULE_10] Thermal level at full disables braking.
// [RULE_11] Resistor overheat alarm or model disables braking.
// [RULE_12] Low-voltage select uses single on/off threshold.
// [RULE_13] Thresholds accepted from zero to maximum setting.
// [RULE_14] Software keeps thresholds above peak rectified supply.
// [RULE_15] Duty over hundred-step period, updated per sample.
`timescale 1ns/1ps
`default_nettype none
`include "brake_chopper_defs.svh"

module brake_chopper_control
   import brake_chopper_pkg::*;
#(
   parameter int MIN_ON_CYCLES = `MIN_ON_CYCLES,
   parameter int STEP_CYCLES   = `STEP_CYCLES
) (
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // Bus voltage samples
   input  wire logic [`VOLT_W-1:0] bus_volt_i,
   input  wire logic               bus_volt_valid_i,
   // Software settings
   input  wire brake_cfg_t         cfg_i,
   // Protection conditions
   input  wire brake_protect_t     protect_i,
   // Gate drive and status
   output logic                    brake_gate_o,
   output logic                    brake_inhibit_o,
   output logic [`DUTY_W-1:0]      duty_o
);

   // Settings above the maximum DC voltage are held at that maximum.
   function automatic logic [`VOLT_W-1:0] clamp_thr(input logic [`VOLT_W-1:0] thr,
                                                    input logic [`VOLT_W-1:0] lim);
      clamp_thr = (thr > lim) ? lim : thr;
   endfunction

   logic [`VOLT_W-1:0] lower_c;
   logic [`VOLT_W-1:0] upper_c;
   logic [`VOLT_W-1:0] low_volt_c;
   brake_mode_t        mode_c;
   logic               inhibit_c;
   logic               demand_c;

   logic [`VOLT_W-1:0] volt_ff;
   logic               start_ff;
   logic [`NUM_W-1:0]  numer_ff;
   logic [`VOLT_W-1:0] denom_ff;
   logic               below_ff;
   logic               above_ff;
   logic               div_done;
   logic [`DUTY_W-1:0] div_duty;
   logic [`DUTY_W-1:0] duty_ff;
   logic [`CNT_W-1:0]  step_cnt_ff;
   logic [`DUTY_W-1:0] phase_ff;
   logic [`CNT_W-1:0]  on_cnt_ff;
   gate_state_t        state_ff;
   gate_state_t        nxt_state;
   logic               gate_ff;
   logic               inhibit_ff;

   // [RULE_13] Threshold range clamp.
   assign lower_c    = clamp_thr(cfg_i.lower_thr, cfg_i.max_dc_voltage_setting);
   assign upper_c    = clamp_thr(cfg_i.upper_thr, cfg_i.max_dc_voltage_setting);
   assign low_volt_c = clamp_thr(cfg_i.low_volt_thr, cfg_i.max_dc_voltage_setting);

   // [RULE_06] Zero threshold disable.
   always_comb begin
      if (cfg_i.low_volt_select && (low_volt_c == '0)) begin
         mode_c = MODE_OFF;
      end else if (cfg_i.low_volt_select) begin
         // [RULE_12] Low-voltage mode select.
         mode_c = MODE_LOW_VOLT;
      end else if (upper_c == '0) begin
         mode_c = MODE_OFF;
      end else if (lower_c >= upper_c) begin
         // [RULE_05] Comparator mode select.
         mode_c = MODE_COMPARE;
      end else begin
         mode_c = MODE_PROPORTIONAL;
      end
   end

   // Trips are OR-ed rather than prioritised: a trip masked by an earlier
   // one must still hold the transistor off.
   always_comb begin
      inhibit_c = (mode_c == MODE_OFF);
      // [RULE_07] Under-voltage inhibit.
      inhibit_c = inhibit_c || protect_i.under_voltage;
      // [RULE_08] Priority trip inhibit.
      inhibit_c = inhibit_c || (|protect_i.priority_trip);
      // [RULE_09] Named trip inhibit.
      inhibit_c = inhibit_c || (|protect_i.trips);
      // [RULE_10] Full thermal level.
      inhibit_c = inhibit_c || (protect_i.thermal_level_pct >= `THERMAL_FULL_PCT);
      // [RULE_11] Resistor overheat inhibit.
      inhibit_c = inhibit_c || protect_i.resistor_hot_alarm ||
                  (protect_i.trip_action[`TRIP_ACTION_RES] && protect_i.resistor_model_hot);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         inhibit_ff <= 1'b1;
      end else begin
         inhibit_ff <= inhibit_c;
      end
   end

   // [RULE_15] Capture each sample.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         volt_ff  <= '0;
         start_ff <= 1'b0;
         numer_ff <= '0;
         denom_ff <= '0;
         below_ff <= 1'b1;
         above_ff <= 1'b0;
      end else begin
         start_ff <= bus_volt_valid_i;
         if (bus_volt_valid_i) begin
            volt_ff  <= bus_volt_i;
            // [RULE_03] Saturation at both ends.
            below_ff <= (bus_volt_i < lower_c) || (lower_c >= upper_c);
            above_ff <= (bus_volt_i >= upper_c);
            // [RULE_04] Round up so any excess gives one step.
            // The product is widened before multiplying so a full-scale span
            // cannot wrap inside a narrower intermediate.
            numer_ff <= `NUM_W'(bus_volt_i - lower_c) * `NUM_W'(`DUTY_STEPS) +
                        `NUM_W'(upper_c - lower_c - `VOLT_W'h001);
            denom_ff <= upper_c - lower_c;
         end
      end
   end

   duty_divider u_duty_divider (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (start_ff && !below_ff && !above_ff),
      .numer_i (numer_ff),
      .denom_i (denom_ff),
      .done_o  (div_done),
      .duty_o  (div_duty)
   );

   // [RULE_03] Duty update.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         duty_ff <= '0;
      end else if (start_ff && above_ff) begin
         duty_ff <= `DUTY_STEPS;
      end else if (start_ff && below_ff) begin
         duty_ff <= '0;
      end else if (div_done) begin
         duty_ff <= div_duty;
      end
   end

   // One step is as long as the least on-time, so even a single-step
   // pulse meets it; the period is therefore 100 ms long.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         step_cnt_ff <= '0;
         phase_ff    <= '0;
      end else if (step_cnt_ff == `CNT_W'(STEP_CYCLES - 1)) begin
         step_cnt_ff <= '0;
         // [RULE_15] Hundred-step period.
         if (phase_ff == `DUTY_STEPS - `DUTY_W'h01) begin
            phase_ff <= '0;
         end else begin
            phase_ff <= phase_ff + `DUTY_W'h01;
         end
      end else begin
         step_cnt_ff <= step_cnt_ff + `CNT_W'h0_0001;
      end
   end

   // [RULE_01] Demand by mode.
   always_comb begin
      case (mode_c)
         MODE_LOW_VOLT:     demand_c = (volt_ff > low_volt_c);
         MODE_COMPARE:      demand_c = (volt_ff >= upper_c);
         MODE_PROPORTIONAL: demand_c = (phase_ff < duty_ff);
         default:           demand_c = 1'b0;
      endcase
   end

   // Inhibits cut the gate at once, even within the least on-time,
   // because protecting the transistor outranks the minimum pulse.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         GATE_OFF: begin
            if (demand_c && !inhibit_ff) begin
               nxt_state = GATE_MIN_ON;
            end
         end
         GATE_MIN_ON: begin
            if (inhibit_ff) begin
               nxt_state = GATE_OFF;
            end else if (on_cnt_ff == `CNT_W'h0_0001) begin
               nxt_state = GATE_ON;
            end
         end
         GATE_ON: begin
            if (inhibit_ff || !demand_c) begin
               nxt_state = GATE_OFF;
            end
         end
         default: nxt_state = GATE_OFF;
      endcase
   end

   // [RULE_02] Least on-time count.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         on_cnt_ff <= '0;
      end else if ((state_ff == GATE_OFF) && (nxt_state == GATE_MIN_ON)) begin
         on_cnt_ff <= `CNT_W'(MIN_ON_CYCLES - 1);
      end else if ((state_ff == GATE_MIN_ON) && (on_cnt_ff != '0)) begin
         on_cnt_ff <= on_cnt_ff - `CNT_W'h0_0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= GATE_OFF;
         gate_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         gate_ff  <= (nxt_state != GATE_OFF);
      end
   end

   assign brake_gate_o    = gate_ff;
   assign brake_inhibit_o = inhibit_ff;
   assign duty_o          = duty_ff;

endmodule
`default_nettype wire

// ===== dv/brake_chopper_checker.sv
// Port assertions for the braking chopper control block.
`timescale 1ns/1ps
`default_nettype none
`include "brake_chopper_defs.svh"
module brake_chopper_checker
   import brake_chopper_pkg::*;
#(
   parameter int MIN_ON_CYCLES = 20,
   parameter int STEP_CYCLES   = 20
) (
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // Block inputs
   input  wire logic [`VOLT_W-1:0] bus_volt_i,
   input  wire logic               bus_volt_valid_i,
   input  wire brake_cfg_t         cfg_i,
   input  wire brake_protect_t     protect_i,
   // Block outputs
   input  wire logic               brake_gate_o,
   input  wire logic               brake_inhibit_o,
   input  wire logic [`DUTY_W-1:0] duty_o
);
   logic [31:0] on_cnt_ff;
   logic        res_hot;
   logic        zero_thr;
   logic        cause;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   assign res_hot  = protect_i.resistor_hot_alarm
                     | (protect_i.trip_action[`TRIP_ACTION_RES] & protect_i.resistor_model_hot);
   assign zero_thr = (cfg_i.low_volt_select ? cfg_i.low_volt_thr : cfg_i.upper_thr) == '0;
   assign cause    = res_hot | zero_thr | protect_i.under_voltage | (|protect_i.priority_trip)
                     | (|protect_i.trips) | (protect_i.thermal_level_pct >= `THERMAL_FULL_PCT);
   // Counts the cycles of the current conduction run.
   always_ff @(posedge clk_i) begin
      if (rst_i || !brake_gate_o) begin
         on_cnt_ff <= 32'h0000_0000;
      end else begin
         on_cnt_ff <= on_cnt_ff + 32'h0000_0001;
      end
   end
   AST_MIN_ON: assert property ($fell(brake_gate_o) && !$past(brake_inhibit_o)
      |-> on_cnt_ff >= MIN_ON_CYCLES) else $error("gate on-time too short");
   AST_INHIBIT_OFF: assert property (brake_inhibit_o |=> !brake_gate_o)
      else $error("gate on while inhibited");
   AST_UNDER_VOLT: assert property (protect_i.under_voltage |=> brake_inhibit_o)
      else $error("under-voltage did not inhibit");
   AST_PRIO_TRIP: assert property ((|protect_i.priority_trip) |=> brake_inhibit_o)
      else $error("priority trip did not inhibit");
   AST_DRIVE_TRIP: assert property ((|protect_i.trips) |=> brake_inhibit_o)
      else $error("drive trip did not inhibit");
   AST_THERMAL: assert property (protect_i.thermal_level_pct >= `THERMAL_FULL_PCT
      |=> brake_inhibit_o) else $error("full thermal level did not inhibit");
   AST_RES_HOT: assert property (res_hot |=> brake_inhibit_o)
      else $error("hot resistor did not inhibit");
   AST_ZERO_THR: assert property (zero_thr |=> brake_inhibit_o)
      else $error("zero threshold did not inhibit");
   AST_NO_CAUSE: assert property (!cause |=> !brake_inhibit_o)
      else $error("inhibit without a cause");
   AST_DUTY_FULL: assert property (bus_volt_valid_i && cfg_i.lower_thr < cfg_i.upper_thr
      && cfg_i.upper_thr <= cfg_i.max_dc_voltage_setting && bus_volt_i >= cfg_i.upper_thr
      |-> ##3 duty_o == `DUTY_STEPS) else $error("duty not full at upper threshold");
   // A sample below both the lower and the upper threshold means zero duty three cycles later.
   AST_DUTY_ZERO: assert property (bus_volt_valid_i && bus_volt_i < cfg_i.lower_thr
      && bus_volt_i < cfg_i.upper_thr
      && cfg_i.lower_thr <= cfg_i.max_dc_voltage_setting |-> ##3 duty_o == '0)
      else $error("duty not zero below lower threshold");
endmodule
`default_nettype wire

// ===== dv/brake_switch_model.sv
// Behavioural braking transistor and resistor, seen from the gate.
`timescale 1ns/1ps
`default_nettype none
module brake_switch_model (
   // Clock and reset
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   // Gate drive
   input  wire logic   gate_i,
   // Conduction record
   output logic [31:0] on_total_o,
   output logic [31:0] last_pulse_o
);
   logic [31:0] run_ff;
   // The resistor dissipates in every cycle that the transistor conducts.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         on_total_o <= '0;
      end else begin
         on_total_o <= on_total_o + {31'h0000_0000, gate_i};
      end
   end
   // A pulse length is known only once the gate drops.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_ff <= '0;
         last_pulse_o <= '0;
      end else if (gate_i) begin
         run_ff <= run_ff + 32'h0000_0001;
      end else if (run_ff != '0) begin
         last_pulse_o <= run_ff;
         run_ff <= '0;
      end
   end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking testbench for the braking chopper control block.
`timescale 1ns/1ps
`default_nettype none
`include "brake_chopper_defs.svh"
module testbench
   import brake_chopper_pkg::*;
;
   localparam int MIN_ON = 20;
   localparam int STEP   = 20;
   logic               clk_i;
   logic               rst_i;
   logic [`VOLT_W-1:0] bus_volt_i;
   logic               bus_volt_valid_i;
   brake_cfg_t         cfg_i;
   brake_protect_t     protect_i;
   logic               gate;
   logic               inhibit;
   logic [`DUTY_W-1:0] duty;
   logic [31:0]        on_total;
   logic [31:0]        last_pulse;
   logic [31:0]        t0;
   int                 fails = 0;
   int                 checks = 0;

   brake_chopper_control #(.MIN_ON_CYCLES(MIN_ON), .STEP_CYCLES(STEP)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .bus_volt_i(bus_volt_i),
      .bus_volt_valid_i(bus_volt_valid_i), .cfg_i(cfg_i), .protect_i(protect_i),
      .brake_gate_o(gate), .brake_inhibit_o(inhibit), .duty_o(duty));
   brake_switch_model u_load (
      .clk_i(clk_i), .rst_i(rst_i), .gate_i(gate),
      .on_total_o(on_total), .last_pulse_o(last_pulse));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (fails == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic pulse(input logic [11:0] v);
      tick(1);
      bus_volt_i = v;
      bus_volt_valid_i = 1'b1;
   endtask

   task automatic sample(input logic [11:0] v);
      pulse(v);
      tick(1);
      bus_volt_valid_i = 1'b0;
      tick(24);
   endtask

   task automatic prop_case(input logic [11:0] l, input logic [11:0] u, input logic [11:0] v);
      logic [31:0] exp;
      cfg_i.lower_thr = l;
      cfg_i.upper_thr = u;
      sample(v);
      exp = (v < l) ? 0 : (v >= u) ? 100 : ((v - l) * 100 + u - l - 1) / (u - l);
      check(duty, exp);
   endtask

   task automatic t_prop();
      prop_case(12'h064, 12'h0c8, 12'h032);
      prop_case(12'h064, 12'h0c8, 12'h085);
      prop_case(12'h064, 12'h0c8, 12'h0c8);
      prop_case(12'h000, 12'hfa0, 12'hbb8);
      prop_case(12'h064, 12'h0c8, 12'h065);
      t0 = on_total;
      tick(100 * STEP);
      check(on_total - t0, STEP);
      check(last_pulse, STEP);
      prop_case(12'h064, 12'h0c8, 12'h096);
      t0 = on_total;
      tick(100 * STEP);
      check(on_total - t0, 50 * STEP);
   endtask

   task automatic t_compare();
      cfg_i.lower_thr = 12'h12c;
      sample(12'h096);
      check(gate, 1'b0);
      check(duty, 7'h00);
      // A one-cycle excursion must still give a full minimum pulse.
      pulse(12'h0c8);
      sample(12'h064);
      tick(20);
      check(gate, 1'b0);
      check(last_pulse >= MIN_ON, 1'b1);
      sample(12'h0c8);
      check(gate, 1'b1);
   endtask

   task automatic t_protect();
      brake_protect_t p;
      for (int i = 0; i < 14; i++) begin
         p = '0;
         case (i)
            0: p.under_voltage = 1'b1;
            1, 2, 3: p.priority_trip[i-1] = 1'b1;
            4, 5, 6, 7: p.trips[i-4] = 1'b1;
            8: p.thermal_level_pct = `THERMAL_FULL_PCT;
            9: p.resistor_hot_alarm = 1'b1;
            10: begin
               p.trip_action[`TRIP_ACTION_RES] = 1'b1;
               p.resistor_model_hot = 1'b1;
            end
            11: p.thermal_level_pct = 7'h63;
            12: p.resistor_model_hot = 1'b1;
            default: p.trip_action = 8'hff;
         endcase
         protect_i = p;
         tick(3);
         check(inhibit, i < 11);
         check(gate, i > 10);
         protect_i = '0;
         tick(8);
      end
   endtask

   task automatic t_lowvolt();
      cfg_i.low_volt_select = 1'b1;
      sample(12'h077);
      check(gate, 1'b0);
      sample(12'h079);
      check(gate, 1'b1);
      sample(12'h078);
      check(gate, 1'b0);
      cfg_i.low_volt_thr = 12'h000;
      tick(3);
      check(inhibit, 1'b1);
      cfg_i = '{12'h064, 12'h000, 12'h078, 1'b0, 12'hfff};
      tick(3);
      check(inhibit, 1'b1);
      cfg_i.upper_thr = 12'h0c8;
      tick(3);
      check(inhibit, 1'b0);
   endtask

   initial begin
      rst_i = 1'b1;
      bus_volt_valid_i = 1'b0;
      bus_volt_i = '0;
      protect_i = '0;
      // Thresholds stay above the peak rectified supply.
      cfg_i = '{12'h064, 12'h0c8, 12'h078, 1'b0, 12'hfff};
      tick(15);
      check(gate, 1'b0);
      check(inhibit, 1'b1);
      check(duty, 7'h00);
      tick(1);
      rst_i = 1'b0;
      t_prop();
      t_compare();
      t_protect();
      t_lowvolt();
      stop_test();
   end

   // The scenarios need about 4500 cycles; over four times that means a hang.
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      stop_test();
   end
endmodule

bind brake_chopper_control brake_chopper_checker #(
   .MIN_ON_CYCLES(MIN_ON_CYCLES), .STEP_CYCLES(STEP_CYCLES)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .bus_volt_i(bus_volt_i),
   .bus_volt_valid_i(bus_volt_valid_i), .cfg_i(cfg_i), .protect_i(protect_i),
   .brake_gate_o(brake_gate_o), .brake_inhibit_o(brake_inhibit_o), .duty_o(duty_o));
`default_nettype wire
